//--- icb_pkg.sv
// Shared constants for the serial-bus command buffer block.
// Assumes a 250 MHz core clock and a bus host that owns the clock line.

package icb_pkg;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic [1:0] WA_RESET = 2'h0;
  localparam logic [1:0] WA_SLEEP = 2'h1;
  localparam logic [1:0] WA_NOOP = 2'h2;
  localparam logic [1:0] WA_CMD = 2'h3;
  localparam logic [7:0] STATUS_POWERUP = 8'h11;
  localparam logic [7:0] GROUP_LEN = 8'h04;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int WAKE_SETTLE_US = 1000;
  localparam int WAKE_SETTLE_CYC =
    (WAKE_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Transfer phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_WORD, PH_DATA, PH_READ, PH_IGNORE
  } icb_phase_t;

endpackage : icb_pkg

//--- icb_fifo.sv
// Small first-in first-out buffer for result bytes.
// Assumes both sides run on the same clock with a synchronous reset.
module icb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [DEPTH-1:0][WIDTH-1:0] mem;
  logic [DEPTH-1:0][WIDTH-1:0] next_mem;
  logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer wrap is explicit so that depths need not be powers of two.
  always_comb begin
    next_mem = mem;
    next_wptr = wptr;
    next_rptr = rptr;
    next_count = count;
    if (push) begin
      next_mem[wptr] = in_data;
      next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
    end
    if (pop) begin
      next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mem <= '0;
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      mem <= next_mem;
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

endmodule : icb_fifo

//--- icb_io.sv
// Client packet layer: address decode, input and output buffers, sleep.
// Assumes a bus host drives the clock pin; the command engine sits on
// the user side and pushes result bytes through the small FIFO.
module icb_io #(
  parameter int IN_DEPTH = 64,
  parameter int OUT_DEPTH = 64,
  parameter int FIFO_DEPTH = 4,
  parameter int WAKE_CYCLES = icb_pkg::WAKE_SETTLE_CYC,
  parameter logic [15:0] POWERUP_CRC = 16'h0000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Command engine side
  output logic cmd_start,
  output logic [7:0] cmd_len,
  input wire logic [$clog2(IN_DEPTH)-1:0] cmd_index,
  output logic [7:0] cmd_byte,
  output logic busy,
  output logic asleep,
  // Result stream
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [7:0] res_data,
  // Completion
  input wire logic exec_done,
  input wire logic exec_fail,
  input wire logic [7:0] fail_code,
  input wire logic [15:0] fail_crc
);

  localparam int IW = $clog2(IN_DEPTH);
  localparam int OW = $clog2(OUT_DEPTH);
  localparam int ICW = $clog2(IN_DEPTH + 1);
  localparam int OCW = $clog2(OUT_DEPTH + 1);
  localparam int WTW = $clog2(WAKE_CYCLES + 1);

  typedef logic [OUT_DEPTH-1:0][7:0] icb_obuf_t;
  typedef logic [IN_DEPTH-1:0][7:0] icb_ibuf_t;

  // Four-byte group: count, status or error, CRC low then high.
  function automatic icb_obuf_t make_group(input logic [7:0] code,
                                           input logic [15:0] crc);
    icb_obuf_t b;
    b = '0;
    b[0] = icb_pkg::GROUP_LEN;
    b[1] = code;
    b[2] = crc[7:0];
    b[3] = crc[15:8];
    return b;
  endfunction : make_group

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

  // Three flops per pin; edges are found between the second and third.
  always_ff @(posedge clock) begin
    scl_m <= scl_pin;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= sda_in;
    sda_s <= sda_m;
    sda_d <= sda_s;
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Result FIFO
  // ----------------------------------------------------------------
  logic f_valid, f_pop;
  logic [7:0] f_data;

  icb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  icb_pkg::icb_phase_t phase, next_phase;
  logic [3:0] cnt, next_cnt;
  logic ackph, next_ackph, hnack, next_hnack, oe, next_oe;
  logic [7:0] sh, next_sh, txb, next_txb, size, next_size;
  logic [7:0] cbyte, next_cbyte;
  icb_ibuf_t in_buf, next_in_buf;
  icb_obuf_t out_buf, next_out_buf;
  logic [ICW-1:0] wr_cnt, next_wr_cnt;
  logic [OCW-1:0] rd_cnt, next_rd_cnt, out_len, next_out_len;
  logic cmd_full, next_cmd_full, busy_q, next_busy;
  logic sleep_q, next_sleep, waking, next_waking;
  logic pend_sleep, next_pend_sleep, start_p, next_start;
  logic [WTW-1:0] wtimer, next_wtimer;
  logic byte_done, tx_load, accept;

  assign byte_done = scl_fall && !ackph && cnt == icb_pkg::BITS_PER_BYTE
                     && phase != icb_pkg::PH_IDLE;
  assign tx_load = scl_fall && ackph && phase == icb_pkg::PH_READ && !hnack;
  assign accept = byte_done && phase == icb_pkg::PH_DATA && !busy_q
                  && !cmd_full && wr_cnt != ICW'(IN_DEPTH)
                  && (wr_cnt == '0 || int'(wr_cnt) < int'(size));
  assign f_pop = busy_q & ~exec_done;

  // Next-state logic for the whole transfer and buffer state.
  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_ackph = ackph;
    next_hnack = hnack;
    next_oe = oe;
    next_sh = sh;
    next_txb = txb;
    next_size = size;
    next_in_buf = in_buf;
    next_out_buf = out_buf;
    next_wr_cnt = wr_cnt;
    next_rd_cnt = rd_cnt;
    next_out_len = out_len;
    next_cmd_full = cmd_full;
    next_busy = busy_q;
    next_sleep = sleep_q;
    next_waking = waking;
    next_pend_sleep = pend_sleep;
    next_wtimer = wtimer;
    next_start = 1'b0;
    next_cbyte = in_buf[cmd_index];
    if (bus_start) begin
      next_phase = icb_pkg::PH_ADDR;
      next_cnt = '0;
      next_ackph = 1'b0;
      next_oe = 1'b0;
    end else if (bus_stop) begin
      next_phase = icb_pkg::PH_IDLE;
      next_cnt = '0;
      next_ackph = 1'b0;
      next_oe = 1'b0;
      if (cmd_full && !busy_q) begin
        next_busy = 1'b1;
        next_cmd_full = 1'b0;
        next_start = 1'b1;
        next_out_len = '0;
      end
      if (pend_sleep) begin
        // Sleep wipes both byte buffers and their counters; the result FIFO keeps its contents.
        next_sleep = 1'b1;
        next_pend_sleep = 1'b0;
        next_busy = 1'b0;
        next_cmd_full = 1'b0;
        next_start = 1'b0;
        next_wr_cnt = '0;
        next_rd_cnt = '0;
        next_out_len = '0;
        next_in_buf = '0;
        next_out_buf = '0;
      end
    end else if (scl_rise && phase != icb_pkg::PH_IDLE) begin
      if (!ackph) begin
        next_sh = {sh[6:0], sda_s};
        next_cnt = cnt + 1'b1;
      end else begin
        next_hnack = sda_s;
      end
    end else if (scl_fall && phase != icb_pkg::PH_IDLE) begin
      if (ackph) begin
        next_ackph = 1'b0;
        next_cnt = '0;
        next_oe = 1'b0;
        if (phase == icb_pkg::PH_READ && hnack) begin
          next_phase = icb_pkg::PH_IGNORE;
        end else if (phase == icb_pkg::PH_READ) begin
          // Past valid data the fill byte goes out; counter saturates.
          next_txb = (rd_cnt < out_len) ? out_buf[OW'(rd_cnt)]
                                        : icb_pkg::FILL_BYTE;
          if (rd_cnt != OCW'(OUT_DEPTH)) begin
            next_rd_cnt = rd_cnt + 1'b1;
          end
          next_oe = ~next_txb[7];
        end
      end else if (cnt == icb_pkg::BITS_PER_BYTE) begin
        next_ackph = 1'b1;
        next_oe = 1'b0;
        unique case (phase)
          icb_pkg::PH_ADDR: begin
            if (sh[7:1] != icb_pkg::DEV_ADDR || waking) begin
              next_phase = icb_pkg::PH_IGNORE;
            end else if (sleep_q) begin
              next_waking = 1'b1;
              next_wtimer = '0;
              next_phase = icb_pkg::PH_IGNORE;
            end else if (sh[0]) begin
              next_wr_cnt = '0;
              if (busy_q || cmd_full || wr_cnt != '0) begin
                next_cmd_full = 1'b0;
                next_phase = icb_pkg::PH_IGNORE;
              end else begin
                next_oe = 1'b1;
                next_hnack = 1'b0;
                next_phase = icb_pkg::PH_READ;
              end
            end else begin
              next_oe = 1'b1;
              next_phase = icb_pkg::PH_WORD;
            end
          end
          icb_pkg::PH_WORD: begin
            next_oe = 1'b1;
            next_phase = icb_pkg::PH_IGNORE;
            unique case (sh[1:0])
              icb_pkg::WA_RESET: begin
                next_wr_cnt = '0;
                next_rd_cnt = '0;
                next_cmd_full = 1'b0;
              end
              icb_pkg::WA_SLEEP: next_pend_sleep = 1'b1;
              icb_pkg::WA_NOOP: next_pend_sleep = pend_sleep;
              icb_pkg::WA_CMD: next_phase = icb_pkg::PH_DATA;
            endcase
          end
          icb_pkg::PH_DATA: begin
            // Bytes past the count, past the buffer or while busy are
            // refused with a NACK so the host sees the overrun.
            if (accept) begin
              next_oe = 1'b1;
              next_in_buf[IW'(wr_cnt)] = sh;
              if (wr_cnt == '0) begin
                next_size = sh;
                next_rd_cnt = '0;
              end
              if (int'(wr_cnt) + 1 >=
                  int'((wr_cnt == '0) ? sh : size)) begin
                next_wr_cnt = '0;
                next_cmd_full = 1'b1;
              end else begin
                next_wr_cnt = wr_cnt + 1'b1;
              end
            end
          end
          icb_pkg::PH_READ: next_oe = 1'b0;
          icb_pkg::PH_IGNORE: next_oe = 1'b0;
          default: next_oe = 1'b0;
        endcase
      end else if (phase == icb_pkg::PH_READ) begin
        next_oe = ~txb[3'(7 - int'(cnt))];
      end
    end
    // Results stream in only while busy, so the FIFO stalls otherwise.
    if (f_pop && f_valid && out_len != OCW'(OUT_DEPTH)) begin
      next_out_buf[OW'(out_len)] = f_data;
      next_out_len = out_len + 1'b1;
    end
    if (busy_q && exec_done) begin
      next_busy = 1'b0;
      next_rd_cnt = '0;
      if (exec_fail) begin
        next_out_buf = make_group(fail_code, fail_crc);
        next_out_len = OCW'(icb_pkg::GROUP_LEN);
      end
    end
    // Wake completes after the settle delay and restores the status group.
    if (waking) begin
      next_wtimer = wtimer + 1'b1;
      if (wtimer == WTW'(WAKE_CYCLES - 1)) begin
        next_waking = 1'b0;
        next_sleep = 1'b0;
        next_wr_cnt = '0;
        next_rd_cnt = '0;
        next_out_buf = make_group(icb_pkg::STATUS_POWERUP, POWERUP_CRC);
        next_out_len = OCW'(icb_pkg::GROUP_LEN);
      end
    end
  end

  // Registers only; reset leaves the power-up status group readable.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase <= icb_pkg::PH_IDLE;
      cnt <= '0;
      ackph <= 1'b0;
      hnack <= 1'b0;
      oe <= 1'b0;
      sh <= '0;
      txb <= '0;
      size <= '0;
      cbyte <= '0;
      in_buf <= '0;
      out_buf <= make_group(icb_pkg::STATUS_POWERUP, POWERUP_CRC);
      wr_cnt <= '0;
      rd_cnt <= '0;
      out_len <= OCW'(icb_pkg::GROUP_LEN);
      cmd_full <= 1'b0;
      busy_q <= 1'b0;
      sleep_q <= 1'b0;
      waking <= 1'b0;
      pend_sleep <= 1'b0;
      wtimer <= '0;
      start_p <= 1'b0;
    end else begin
      phase <= next_phase;
      cnt <= next_cnt;
      ackph <= next_ackph;
      hnack <= next_hnack;
      oe <= next_oe;
      sh <= next_sh;
      txb <= next_txb;
      size <= next_size;
      cbyte <= next_cbyte;
      in_buf <= next_in_buf;
      out_buf <= next_out_buf;
      wr_cnt <= next_wr_cnt;
      rd_cnt <= next_rd_cnt;
      out_len <= next_out_len;
      cmd_full <= next_cmd_full;
      busy_q <= next_busy;
      sleep_q <= next_sleep;
      waking <= next_waking;
      pend_sleep <= next_pend_sleep;
      wtimer <= next_wtimer;
      start_p <= next_start;
    end
  end

  // Open-drain data pin: only ever pulls low.
  assign sda_out = 1'b0;
  assign sda_oe = oe;
  assign cmd_start = start_p;
  assign cmd_len = size;
  assign cmd_byte = cbyte;
  assign busy = busy_q;
  assign asleep = sleep_q | waking;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_FULL_NACK: assert property (@(posedge clock) disable iff (sys_rst)
    byte_done && phase == icb_pkg::PH_DATA && cmd_full |=> !sda_oe)
    else $error("byte past the size was acknowledged");
  AST_PWRUP: assert property (@(posedge clock)
    $fell(sys_rst) |-> out_len == OCW'(icb_pkg::GROUP_LEN)
      && out_buf[1] == icb_pkg::STATUS_POWERUP)
    else $error("power-up status group missing");
  AST_FAIL_GROUP: assert property (@(posedge clock) disable iff (sys_rst)
    busy_q && exec_done && exec_fail |=> out_buf[1] == $past(fail_code)
      && out_len == OCW'(icb_pkg::GROUP_LEN) && !busy_q)
    else $error("error group not framed");
  AST_FILL: assert property (@(posedge clock) disable iff (sys_rst)
    tx_load && rd_cnt >= out_len |=> txb == icb_pkg::FILL_BYTE
      && rd_cnt >= $past(rd_cnt))
    else $error("read past end did not return fill byte");
  AST_WA_RESET: assert property (@(posedge clock) disable iff (sys_rst)
    byte_done && phase == icb_pkg::PH_WORD && sh[1:0] == icb_pkg::WA_RESET
    |=> rd_cnt == '0 && wr_cnt == '0 && sda_oe)
    else $error("reset word did not clear counters");
  AST_RD_NACK: assert property (@(posedge clock) disable iff (sys_rst)
    byte_done && phase == icb_pkg::PH_ADDR && !asleep
      && sh == {icb_pkg::DEV_ADDR, 1'b1} && (wr_cnt != '0 || busy_q)
    |=> !sda_oe && wr_cnt == '0 ##1 phase != icb_pkg::PH_READ)
    else $error("read address not refused");
  AST_LEN_ABORT: assert property (@(posedge clock) disable iff (sys_rst)
    accept && wr_cnt == '0 |=> rd_cnt == '0 && sda_oe && size == $past(sh))
    else $error("length byte did not abandon the read");
  AST_BUSY_ON_STOP: assert property (@(posedge clock) disable iff (sys_rst)
    bus_stop && cmd_full && !busy_q && !pend_sleep |=> busy_q && cmd_start
      ##1 !cmd_start)
    else $error("stop did not start execution");
  AST_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
    waking && wtimer == WTW'(WAKE_CYCLES - 1) |=> !asleep
      && out_buf[1] == icb_pkg::STATUS_POWERUP)
    else $error("wake did not finish after the settle delay");

endmodule : icb_io

//--- icb_host_model.sv
// Behavioural bus host that owns the clock line and pulls data low.
// Assumes the bench resolves the data wire with a pull-up to high.
module icb_host_model (
  // Bus pins
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // Bit and frame tasks
  // --------------------------------------------------------------
  localparam int HALF = 24;

  // The clock stands high between frames, as an idle bus requires.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One bit period; data only moves while the clock is low.
  task automatic bit_cycle(input logic b, output logic r);
    sda_low = ~b;
    #(HALF);
    scl = 1'b1;
    #(HALF);
    r = sda;
    scl = 1'b0;
  endtask : bit_cycle

  // Data falls while the clock is high; also serves as a repeated start.
  task automatic start();
    sda_low = 1'b0;
    #(HALF);
    scl = 1'b1;
    #(HALF);
    sda_low = 1'b1;
    #(HALF);
    scl = 1'b0;
  endtask : start

  // Every frame ends here, so the device may begin execution.
  task automatic stop();
    sda_low = 1'b1;
    #(HALF);
    scl = 1'b1;
    #(HALF);
    sda_low = 1'b0;
    #(HALF);
  endtask : stop

  // Byte out, most significant bit first; ack is the device's answer.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], r);
    end
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask : wr

  // Byte in; the host acknowledges every byte but the last.
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, d[i]);
    end
    bit_cycle(~ack, r);
  endtask : rd
endmodule : icb_host_model

//--- tb_i2c_command_buffer_io.sv
// Self-checking bench for the client packet layer.
// Assumes the bus host model and the design files compile before it.
module tb_i2c_command_buffer_io;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------
  logic clock, sys_rst, scl, sda_low, sda, sda_out, sda_oe;
  logic cmd_start, busy, asleep, res_valid, res_ready, exec_done;
  logic exec_fail, ack;
  logic [7:0] cmd_len, cmd_byte, res_data, fail_code;
  logic [2:0] cmd_index;
  logic [15:0] fail_crc;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_start = 0;

  // Open-drain wire: either party pulls low, otherwise the pull-up wins.
  assign sda = ~(sda_low | (sda_oe & ~sda_out));

  icb_host_model host (.scl(scl), .sda_low(sda_low), .sda(sda));

  icb_io #(.IN_DEPTH(8), .OUT_DEPTH(8), .WAKE_CYCLES(200),
    .POWERUP_CRC(16'h5aa5)) dut (
    .clock(clock), .sys_rst(sys_rst), .scl_pin(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .cmd_start(cmd_start),
    .cmd_len(cmd_len), .cmd_index(cmd_index), .cmd_byte(cmd_byte),
    .busy(busy), .asleep(asleep), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .exec_done(exec_done),
    .exec_fail(exec_fail), .fail_code(fail_code), .fail_crc(fail_crc));

  // Clock and a hang guard sized well above the expected run.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // The start pulse is over before a frame task returns, so count it here.
  always @(posedge clock) begin
    if (cmd_start === 1'b1) begin
      n_start <= n_start + 1;
    end
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Address byte after a start, with its expected answer.
  task automatic addr(input logic [7:0] a, input logic exp_ack);
    @(negedge clock);
    host.start();
    host.wr(a, ack);
    chk(ack, exp_ack);
  endtask : addr

  // Write frame: n bytes taken from the top of v, answers from acks.
  task automatic wseq(input logic [47:0] v, input int n,
                      input logic [5:0] acks);
    addr(v[47:40], acks[5]);
    for (int i = 1; i < n; i++) begin
      host.wr(v[47-8*i -: 8], ack);
      chk(ack, acks[5-i]);
    end
    host.stop();
  endtask : wseq

  // Read frame of n bytes; the first expected byte is byte n-1 of e.
  task automatic rseq(input logic [31:0] e, input int n);
    logic [7:0] d;
    addr(8'h81, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      host.rd(i != 0, d);
      chk(d, e[8*i +: 8]);
    end
    host.stop();
  endtask : rseq

  // Bounded wait for the command to be taken; polls the busy output every clock, up to 300 cycles.
  task automatic wait_busy();
    for (int i = 0; i < 300 && busy !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
  endtask : wait_busy

  // One-cycle completion pulse from the engine side.
  task automatic finish_cmd(input logic fail);
    repeat (20) @(negedge clock);
    exec_done = 1'b1;
    exec_fail = fail;
    @(negedge clock);
    exec_done = 1'b0;
    exec_fail = 1'b0;
  endtask : finish_cmd

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_powerup();
    addr(8'h90, 1'b0);
    host.stop();
    rseq(32'h0411a55a, 4);
    rseq(32'h0000ffff, 2);
    wseq(48'h8000_0000_0000, 2, 6'b110000);
    rseq(32'h00000411, 2);
  endtask : t_powerup

  // Results wait in the small buffer until the command is taken.
  task automatic t_command();
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      res_valid = 1'b1;
      res_data = 8'hc1 + 8'(i);
    end
    @(negedge clock);
    chk(res_ready, 1'b0);
    res_valid = 1'b0;
    wseq(48'h80fb_03aa_0000, 4, 6'b111100);
    addr(8'h81, 1'b0);
    host.stop();
    wseq(48'h8003_0311_2233, 6, 6'b111110);
    wait_busy();
    chk(busy, 1'b1);
    chk(16'(n_start), 16'h0001);
    chk(cmd_len, 8'h03);
    chk(cmd_byte, 8'h11);
    addr(8'h81, 1'b0);
    host.stop();
    finish_cmd(1'b0);
    rseq(32'hc1c2c3c4, 4);
    rseq(32'h000000ff, 1);
  endtask : t_command

  task automatic t_fail_sleep();
    wseq(48'h8003_0100_0000, 3, 6'b111000);
    wait_busy();
    chk(16'(n_start), 16'h0002);
    fail_code = 8'h0f;
    fail_crc = 16'h1234;
    finish_cmd(1'b1);
    rseq(32'h040f3412, 4);
    wseq(48'h8000_0000_0000, 2, 6'b110000);
    rseq(32'h00000004, 1);
    wseq(48'h8002_0000_0000, 2, 6'b110000);
    rseq(32'h0000000f, 1);
    wseq(48'h8001_0000_0000, 2, 6'b110000);
    chk(asleep, 1'b1);
    addr(8'h81, 1'b0);
    chk(asleep, 1'b1);
    host.stop();
    addr(8'h80, 1'b0);
    host.stop();
    repeat (100) @(negedge clock);
    chk(asleep, 1'b0);
    rseq(32'h0411a55a, 4);
  endtask : t_fail_sleep

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    cmd_index = 3'h1;
    res_valid = 1'b0;
    res_data = 8'h00;
    exec_done = 1'b0;
    exec_fail = 1'b0;
    fail_code = 8'h00;
    fail_crc = 16'h0000;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    t_powerup();
    t_command();
    t_fail_sleep();
    report_and_stop();
  end
endmodule : tb_i2c_command_buffer_io
